// [src/fifo_reset_retransmit_control.v]
// fifo_reset_retransmit_control.v: reset, mode and retransmit control
// assumes write_tick/read_tick mark write and read clock edges
// assumes reset and strap pins are asynchronous to core_clk
//
// Summary of operation
// - retransmit pin sampled low on a read edge starts setup; it is synced
// - standard mode: empty flag low at setup start, read pointer rewound
// - standard mode: empty flag high ends setup; every read needs enable
// - fall-through: output ready high at setup start, pointer rewound
// - fall-through: first word and ready-low end setup without enable
// - almost-empty updates second read edge after setup; half-full at once
// - almost-full updates on second write edge after setup
// - master reset zeroes pointers; almost-empty low, others high
// - master reset latches mode; standard or fall-through flag levels
// - load pin low at master reset: offsets 127, parallel loading
// - load pin high at master reset: offsets 1023, serial loading
// - offset registers readable in parallel in either method
// - master reset clears output data register
// - partial reset zeroes pointers; almost-empty low, others high
// - partial reset keeps mode and sets that mode's flag levels
// - partial reset keeps offsets and method, clears output register
// - fall-through: first word out after three read edges
// - mode pin becomes serial offset input after master reset
// - write edges drive full, almost-full; they only lower half-full
// - standard mode: empty flag rises two read edges after write
// - fall-through: ready high on a true read or at setup start; data stays
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fifo_rrc_defs.vh"
module fifo_reset_retransmit_control #(
  parameter DATA_W = `FRC_DATA_W,
  parameter ADDR_W = `FRC_ADDR_W,
  parameter OFS_W = `FRC_OFS_W
) (
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  input wire master_reset_n,
  input wire partial_reset_n,
  input wire retransmit_n,
  input wire mode_select_serial_in,
  input wire offset_load_n,
  input wire serial_en_n,
  input wire write_tick,
  input wire write_en_n,
  input wire [DATA_W-1:0] write_data_bus,
  input wire read_tick,
  input wire read_en_n,
  output reg [DATA_W-1:0] read_data_bus,
  output reg empty_flag_n,
  output reg full_flag_n,
  output reg almost_empty_n,
  output reg almost_full_n,
  output reg half_full_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam PW = ADDR_W + 1;
  localparam [PW-1:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
  localparam [PW-1:0] HALF = {2'b01, {(ADDR_W-1){1'b0}}};

  function [31:0] mergeStrb;
    input [31:0] oldW;
    input [31:0] newW;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        mergeStrb[i*8 +: 8] = strb[i] ? newW[i*8 +: 8] : oldW[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [4:0] pinSync;
  wire mrsS = pinSync[0];
  wire prsS = pinSync[1];
  wire rtS = pinSync[2];
  wire modeS = pinSync[3];
  wire ldS = pinSync[4];

  pin_sync #(
    .W(5),
    .RST_VAL(5'h17)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pinIn({offset_load_n, mode_select_serial_in, retransmit_n,
            partial_reset_n, master_reset_n}),
    .pinSync(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  reg fall_through_mode_q;
  reg serial_q;
  reg rtBusy_q;
  reg rtLow_q;
  reg outValid_q;
  reg [PW-1:0] wrPtr_q;
  reg [PW-1:0] rdPtr_q;
  reg [PW-1:0] wpR1_q;
  reg [PW-1:0] wpR2_q;
  reg [PW-1:0] rpW1_q;
  reg [PW-1:0] rpW2_q;
  reg [OFS_W-1:0] emptyOfs_q;
  reg [OFS_W-1:0] fullOfs_q;
  reg [2*OFS_W-1:0] shift_q;
  wire [31:0] defPar = `FRC_OFS_DEF_PAR;
  wire [31:0] defSer = `FRC_OFS_DEF_SER;
  wire [DATA_W-1:0] ramData;

  ////////////////////////////////////////////////////////////////////////
  // next-state terms
  reg wrDo;
  reg rdDo;
  reg rtStart;
  reg [PW-1:0] wrPtr_d;
  reg [PW-1:0] rdPtr_d;
  reg [PW-1:0] wrFill;
  reg [PW-1:0] rdFill;
  reg avail;
  reg axiWrDo;
  reg wrHit;

  always @* begin
    rtStart = read_tick && !rtS && !rtLow_q && !rtBusy_q;
    wrDo = write_tick && !write_en_n && ldS && !rtBusy_q &&
           ((wrPtr_q - rpW2_q) != DEPTH);
    avail = (wpR2_q != rdPtr_q);
    rdDo = 1'b0;
    if (read_tick && !rtStart && avail) begin
      if (rtBusy_q) begin
        rdDo = fall_through_mode_q;
      end else if (fall_through_mode_q) begin
        rdDo = !outValid_q || !read_en_n;
      end else begin
        rdDo = !read_en_n;
      end
    end
    wrPtr_d = wrPtr_q + {{(PW-1){1'b0}}, wrDo};
    rdPtr_d = rtStart ? {PW{1'b0}} : rdPtr_q + {{(PW-1){1'b0}}, rdDo};
    wrFill = wrPtr_d - rpW1_q;
    rdFill = wpR1_q - rdPtr_d;
  end

  fifo_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_ram (
    .core_clk(core_clk),
    .wrEn(wrDo && clk_en && mrsS && prsS),
    .wrAddr(wrPtr_q[ADDR_W-1:0]),
    .wrData(write_data_bus),
    .rdAddr(rdPtr_q[ADDR_W-1:0]),
    .rdData(ramData)
  );

  ////////////////////////////////////////////////////////////////////////
  // fifo control
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_through_mode_q <= 1'b0;
      serial_q <= 1'b0;
      rtBusy_q <= 1'b0;
      rtLow_q <= 1'b0;
      outValid_q <= 1'b0;
      wrPtr_q <= {PW{1'b0}};
      rdPtr_q <= {PW{1'b0}};
      wpR1_q <= {PW{1'b0}};
      wpR2_q <= {PW{1'b0}};
      rpW1_q <= {PW{1'b0}};
      rpW2_q <= {PW{1'b0}};
      emptyOfs_q <= {OFS_W{1'b0}};
      fullOfs_q <= {OFS_W{1'b0}};
      shift_q <= {(2*OFS_W){1'b0}};
      read_data_bus <= {DATA_W{1'b0}};
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      half_full_n <= 1'b1;
    end else if (clk_en) begin
      if (!mrsS || !prsS) begin
        if (!mrsS) begin
          fall_through_mode_q <= modeS;
          serial_q <= ldS;
          shift_q <= {(2*OFS_W){1'b0}};
          emptyOfs_q <= ldS ? defSer[OFS_W-1:0] : defPar[OFS_W-1:0];
          fullOfs_q <= ldS ? defSer[OFS_W-1:0] : defPar[OFS_W-1:0];
        end
        wrPtr_q <= {PW{1'b0}};
        rdPtr_q <= {PW{1'b0}};
        wpR1_q <= {PW{1'b0}};
        wpR2_q <= {PW{1'b0}};
        rpW1_q <= {PW{1'b0}};
        rpW2_q <= {PW{1'b0}};
        rtBusy_q <= 1'b0;
        rtLow_q <= 1'b0;
        outValid_q <= 1'b0;
        read_data_bus <= {DATA_W{1'b0}};
        empty_flag_n <= !mrsS ? modeS : fall_through_mode_q;
        full_flag_n <= !mrsS ? !modeS : !fall_through_mode_q;
        almost_empty_n <= 1'b0;
        almost_full_n <= 1'b1;
        half_full_n <= 1'b1;
      end else begin
        wrPtr_q <= wrPtr_d;
        rdPtr_q <= rdPtr_d;
        half_full_n <= !((wrPtr_d - rdPtr_d) > HALF);
        if (write_tick) begin
          rpW1_q <= rdPtr_q;
          rpW2_q <= rpW1_q;
          full_flag_n <= fall_through_mode_q ? (wrFill == DEPTH) : (wrFill != DEPTH);
          almost_full_n <= (wrFill < DEPTH - {1'b0, fullOfs_q});
          if (!offset_load_n && !serial_en_n && serial_q) begin
            shift_q <= {modeS, shift_q[2*OFS_W-1:1]};
          end
        end
        if (axiWrDo && wrHit) begin
          if (s_axi_awaddr[3:0] == `FRC_REG_EMPTY_OFS) begin
            emptyOfs_q <= s_axi_wdata[OFS_W-1:0];
          end
          if (s_axi_awaddr[3:0] == `FRC_REG_FULL_OFS) begin
            fullOfs_q <= s_axi_wdata[OFS_W-1:0];
          end
        end
        if (read_tick) begin
          wpR1_q <= wrPtr_q;
          wpR2_q <= wpR1_q;
          if (!rtS) begin
            rtLow_q <= 1'b1;
          end else begin
            rtLow_q <= 1'b0;
          end
          if (rdDo) begin
            read_data_bus <= ramData;
          end
          if (rtStart) begin
            rtBusy_q <= 1'b1;
            outValid_q <= 1'b0;
            empty_flag_n <= fall_through_mode_q;
          end else if (fall_through_mode_q) begin
            rtBusy_q <= 1'b0;
            if (rdDo) begin
              outValid_q <= 1'b1;
              empty_flag_n <= 1'b0;
            end else if (!rtBusy_q && outValid_q && !read_en_n) begin
              outValid_q <= 1'b0;
              empty_flag_n <= 1'b1;
            end
          end else begin
            rtBusy_q <= 1'b0;
            empty_flag_n <= (wpR1_q != rdPtr_d);
          end
          if (!rtBusy_q && !rtStart) begin
            almost_empty_n <= (rdFill > {1'b0, emptyOfs_q});
          end
        end
        if (write_tick && !offset_load_n && !serial_en_n && serial_q &&
            shift_q[0] == 1'b0) begin
          emptyOfs_q <= shift_q[OFS_W:1];
          fullOfs_q <= {modeS, shift_q[2*OFS_W-1:OFS_W+1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus
  reg [31:0] rdWord;
  reg rdHit;

  always @* begin
    rdWord = 32'h00000000;
    rdHit = 1'b1;
    case (s_axi_araddr[3:0])
      `FRC_REG_STATUS: begin
        rdWord[`FRC_ST_EF] = empty_flag_n;
        rdWord[`FRC_ST_FF] = full_flag_n;
        rdWord[`FRC_ST_AE] = almost_empty_n;
        rdWord[`FRC_ST_AF] = almost_full_n;
        rdWord[`FRC_ST_HF] = half_full_n;
        rdWord[`FRC_ST_FALL_THROUGH_MODE] = fall_through_mode_q;
        rdWord[`FRC_ST_SER] = serial_q;
        rdWord[`FRC_ST_RT] = rtBusy_q;
        rdWord[`FRC_ST_FILL +: PW] = wrPtr_q - rdPtr_q;
      end
      `FRC_REG_EMPTY_OFS: begin
        rdWord[OFS_W-1:0] = emptyOfs_q;
      end
      `FRC_REG_FULL_OFS: begin
        rdWord[OFS_W-1:0] = fullOfs_q;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:4] != 28'h0000000) begin
      rdHit = 1'b0;
    end
  end

  reg [31:0] mergedW;

  always @* begin
    axiWrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    mergedW = mergeStrb(32'h00000000, s_axi_wdata, s_axi_wstrb);
    wrHit = (s_axi_awaddr[31:4] == 28'h0000000) &&
            (s_axi_awaddr[3:0] == `FRC_REG_EMPTY_OFS ||
             s_axi_awaddr[3:0] == `FRC_REG_FULL_OFS) &&
            !serial_q && (s_axi_wstrb == 4'hF || mergedW == s_axi_wdata);
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FRC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FRC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end
      if (axiWrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // fifo_reset_retransmit_control

// [src/fifo_rrc_defs.vh]
// fifo_rrc_defs.vh: constants for the fifo reset/retransmit control
// assumes inclusion by every design file of this block
`ifndef FIFO_RRC_DEFS_VH
`define FIFO_RRC_DEFS_VH

// geometry
`define FRC_DATA_W 18
`define FRC_ADDR_W 13
`define FRC_OFS_W 13

// default offsets chosen at master reset
`define FRC_OFS_DEF_PAR 32'h0000007F
`define FRC_OFS_DEF_SER 32'h000003FF

// register byte addresses
`define FRC_REG_STATUS 4'h0
`define FRC_REG_EMPTY_OFS 4'h4
`define FRC_REG_FULL_OFS 4'h8

// status field positions
`define FRC_ST_EF 0
`define FRC_ST_FF 1
`define FRC_ST_AE 2
`define FRC_ST_AF 3
`define FRC_ST_HF 4
`define FRC_ST_FALL_THROUGH_MODE 5
`define FRC_ST_SER 6
`define FRC_ST_RT 7
`define FRC_ST_FILL 16

// bus answers
`define FRC_RESP_OKAY 2'h0
`define FRC_RESP_SLVERR 2'h2

`endif

// [src/pin_sync.v]
// pin_sync.v: two-stage synchroniser for asynchronous pins
// assumes pins change freely with respect to core_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire core_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [W-1:0] pinIn,
  output reg [W-1:0] pinSync
);
  reg [W-1:0] stage1_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= RST_VAL;
      pinSync <= RST_VAL;
    end else if (clk_en) begin
      stage1_q <= pinIn;
      pinSync <= stage1_q;
    end
  end
endmodule // pin_sync

// [src/fifo_ram.v]
// fifo_ram.v: storage array, one write port, combinational read
// assumes write enable already qualified by the controller
`timescale 1ns/1ps
module fifo_ram #(
  parameter DATA_W = 18,
  parameter ADDR_W = 13
) (
  input wire core_clk,
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [DATA_W-1:0] wrData,
  input wire [ADDR_W-1:0] rdAddr,
  output wire [DATA_W-1:0] rdData
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];
endmodule // fifo_ram

// [dv/fifo_rrc_asserts.sv]
// fifo_rrc_asserts.sv: port checks of reset, mode and flag timing
// assumes clk_en held high and pins held several cycles per change
`timescale 1ns/1ps
module fifo_rrc_asserts #(
  parameter DATA_W = 18
) (
  input wire core_clk,
  input wire rst_b,
  input wire master_reset_n,
  input wire partial_reset_n,
  input wire mode_select_serial_in,
  input wire write_tick,
  input wire read_tick,
  input wire [DATA_W-1:0] read_data_bus,
  input wire empty_flag_n,
  input wire full_flag_n,
  input wire almost_empty_n,
  input wire almost_full_n,
  input wire half_full_n,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  sequence s_rst;
    (!master_reset_n || !partial_reset_n) [*4];
  endsequence
  sequence s_std;
    (!master_reset_n && !mode_select_serial_in) [*4];
  endsequence
  sequence s_ff;
    (!master_reset_n && mode_select_serial_in) [*4];
  endsequence
  sequence s_quiet;
    (master_reset_n && partial_reset_n) [*4];
  endsequence
  property p_rst_flags;
    s_rst |-> !almost_empty_n && almost_full_n && half_full_n;
  endproperty
  a_rst_flags: assert property (p_rst_flags)
    else $error("reset flag levels wrong");
  property p_rst_data;
    s_rst |-> read_data_bus == '0;
  endproperty
  a_rst_data: assert property (p_rst_data)
    else $error("output register not cleared");
  property p_std;
    s_std |-> !empty_flag_n && full_flag_n;
  endproperty
  a_std: assert property (p_std)
    else $error("standard mode flag levels wrong");
  property p_ff;
    s_ff |-> empty_flag_n && !full_flag_n;
  endproperty
  a_ff: assert property (p_ff)
    else $error("fall-through flag levels wrong");
  property p_af_wclk;
    s_quiet ##1 $changed(almost_full_n) |-> $past(write_tick);
  endproperty
  a_af_wclk: assert property (p_af_wclk)
    else $error("almost-full moved without write edge");
  property p_full_wclk;
    s_quiet ##1 $changed(full_flag_n) |-> $past(write_tick);
  endproperty
  a_full_wclk: assert property (p_full_wclk)
    else $error("full flag moved without write edge");
  property p_ae_rclk;
    s_quiet ##1 $changed(almost_empty_n) |-> $past(read_tick);
  endproperty
  a_ae_rclk: assert property (p_ae_rclk)
    else $error("almost-empty moved without read edge");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
endmodule // fifo_rrc_asserts

bind fifo_reset_retransmit_control fifo_rrc_asserts #(.DATA_W(DATA_W)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .master_reset_n(master_reset_n),
  .partial_reset_n(partial_reset_n), .read_tick(read_tick),
  .mode_select_serial_in(mode_select_serial_in), .write_tick(write_tick),
  .read_data_bus(read_data_bus), .empty_flag_n(empty_flag_n),
  .full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n),
  .almost_full_n(almost_full_n), .half_full_n(half_full_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [dv/fifo_peer.sv]
// fifo_peer.sv: writer and reader logic as one-cycle clock ticks
// assumes tasks are entered just after a core_clk rising edge
`timescale 1ns/1ps
module fifo_peer (
  input wire core_clk,
  output logic write_tick = 1'h0,
  output logic write_en_n = 1'h1,
  output logic [17:0] write_data_bus = 18'h0,
  output logic read_tick = 1'h0,
  output logic read_en_n = 1'h1,
  output logic retransmit_n = 1'h1
);
  ////////////////////////////////////////////////////////////
  task wr(input logic [17:0] d);
    write_en_n <= 1'h0;
    write_data_bus <= d;
    write_tick <= 1'h1;
    @(posedge core_clk);
    write_tick <= 1'h0;
    write_en_n <= 1'h1;
    write_data_bus <= ~d;
    repeat (2) @(posedge core_clk);
  endtask
  task rd(input logic en);
    read_en_n <= !en;
    read_tick <= 1'h1;
    @(posedge core_clk);
    read_tick <= 1'h0;
    read_en_n <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask
  task rt_setup();
    retransmit_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    rd(1'h0);
    retransmit_n <= 1'h1;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // fifo_peer

// [dv/testbench.sv]
// testbench.sv: reset, offsets, retransmit and fall-through checks
// assumes fifo_peer model and the bound checker
`timescale 1ns/1ps
`include "fifo_rrc_defs.vh"
module testbench;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;
    logic [1:0] r;} row_t;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic master_reset_n = 1'h0;
  logic partial_reset_n = 1'h1;
  logic mode_select_serial_in = 1'h0;
  logic offset_load_n = 1'h0;
  logic clk_en = 1'h1, serial_en_n = 1'h1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire write_tick, write_en_n, read_tick, read_en_n, retransmit_n;
  wire [17:0] write_data_bus, read_data_bus;
  wire empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_full_n;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [22:0] outs = {read_data_bus, empty_flag_n, full_flag_n, almost_empty_n,
    almost_full_n, half_full_n};
  integer miscompares = 0, comparisons = 0;
  logic [17:0] words [3] = '{18'h11111, 18'h2A2A2, 18'h3C3C3};
  row_t rows [8] = '{
    '{1'h0, 8'h04, `FRC_OFS_DEF_PAR, `FRC_RESP_OKAY},
    '{1'h0, 8'h08, `FRC_OFS_DEF_PAR, `FRC_RESP_OKAY},
    '{1'h1, 8'h04, 32'h00000055, `FRC_RESP_OKAY},
    '{1'h1, 8'h08, 32'h00001FFF, `FRC_RESP_OKAY},
    '{1'h0, 8'h04, 32'h00000055, `FRC_RESP_OKAY},
    '{1'h0, 8'h08, 32'h00001FFF, `FRC_RESP_OKAY},
    '{1'h1, 8'h0C, 32'h00000000, `FRC_RESP_SLVERR},
    '{1'h0, 8'h10, 32'h00000000, `FRC_RESP_SLVERR}};
  ////////////////////////////////////////////////////////////
  always #10 core_clk = ~core_clk;
  fifo_peer i_peer (.core_clk(core_clk), .write_tick(write_tick),
    .write_en_n(write_en_n), .write_data_bus(write_data_bus),
    .read_tick(read_tick), .read_en_n(read_en_n), .retransmit_n(retransmit_n));
  fifo_reset_retransmit_control i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .retransmit_n(retransmit_n),
    .mode_select_serial_in(mode_select_serial_in),
    .offset_load_n(offset_load_n), .serial_en_n(serial_en_n),
    .write_tick(write_tick), .write_en_n(write_en_n),
    .write_data_bus(write_data_bus), .read_tick(read_tick),
    .read_en_n(read_en_n), .read_data_bus(read_data_bus),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
    .half_full_n(half_full_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic [1:0] r);
    @(posedge core_clk);
    q = 32'h0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      q = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
    end
  endtask
  task finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin : main
    logic [31:0] q;
    logic [1:0] r;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    master_reset_n <= 1'h1;
    offset_load_n <= 1'h1;
    repeat (5) @(posedge core_clk);
    chk(outs, 32'h0B);
    for (int i = 0; i < 8; i++) begin
      bus(rows[i].wr, {24'h0, rows[i].a}, rows[i].d, q, r);
      chk(r, rows[i].r);
      if (!rows[i].wr && rows[i].r == `FRC_RESP_OKAY) chk(q, rows[i].d);
    end
    // partial strobe refused, offset kept
    s_axi_wstrb <= 4'h3;
    bus(1'h1, 32'h4, 32'h00010000, q, r);
    chk(r, `FRC_RESP_SLVERR);
    s_axi_wstrb <= 4'hF;
    for (int i = 0; i < 3; i++) i_peer.wr(words[i]);
    i_peer.rd(1'h0);
    chk(empty_flag_n, 1'h0);
    i_peer.rd(1'h0);
    chk(empty_flag_n, 1'h1);
    for (int i = 0; i < 2; i++) begin
      i_peer.rd(1'h1);
      chk(read_data_bus, words[i]);
    end
    // frozen clock: read tick has no effect
    clk_en <= 1'h0;
    i_peer.rd(1'h1);
    clk_en <= 1'h1;
    chk(read_data_bus, words[1]);
    i_peer.rt_setup();
    chk(empty_flag_n, 1'h0);
    i_peer.rd(1'h1);
    chk({empty_flag_n, read_data_bus}, {1'h1, words[1]});
    for (int i = 0; i < 3; i++) begin
      i_peer.rd(1'h1);
      chk(read_data_bus, words[i]);
    end
    partial_reset_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    chk(outs, 32'h0B);
    partial_reset_n <= 1'h1;
    repeat (5) @(posedge core_clk);
    bus(1'h0, 32'h4, 32'h0, q, r);
    chk(q, 32'h55);
    mode_select_serial_in <= 1'h1;
    offset_load_n <= 1'h1;
    master_reset_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    chk(outs, 32'h13);
    master_reset_n <= 1'h1;
    repeat (5) @(posedge core_clk);
    bus(1'h0, 32'h8, 32'h0, q, r);
    chk(q, `FRC_OFS_DEF_SER);
    bus(1'h1, 32'h4, 32'h11, q, r);
    chk(r, `FRC_RESP_SLVERR);
    i_peer.wr(words[0]);
    i_peer.wr(words[1]);
    i_peer.rd(1'h0);
    i_peer.rd(1'h0);
    chk(empty_flag_n, 1'h1);
    i_peer.rd(1'h0);
    chk({empty_flag_n, read_data_bus}, {1'h0, words[0]});
    i_peer.rd(1'h1);
    chk({empty_flag_n, read_data_bus}, {1'h0, words[1]});
    i_peer.rt_setup();
    chk(empty_flag_n, 1'h1);
    i_peer.rd(1'h0);
    chk({empty_flag_n, read_data_bus}, {1'h0, words[0]});
    i_peer.rd(1'h1);
    chk(read_data_bus, words[1]);
    i_peer.rd(1'h1);
    chk({empty_flag_n, read_data_bus}, {1'h1, words[1]});
    finish_test;
  end
  initial begin : watchdog
    #400000;
    miscompares++;
    finish_test;
  end
endmodule // testbench
